// File: hw/vdm_top.sv
`timescale 1ns/10ps
`include "vdm_regs.svh"


module vdm_top #(
    parameter int TICK_CYCLES = `VDM_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output wire logic        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output wire logic        s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output wire logic        s_axi_arready,
    // AXI4-Lite read data
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Phase-to-phase magnitudes, percent of nominal
    input  wire logic [15:0] volt_ab,
    input  wire logic [15:0] volt_bc,
    input  wire logic [15:0] volt_ca,
    // Blocking input from a pin
    input  wire logic        block_pin,
    // Status levels
    output wire logic        sag_det,
    output wire logic        swell_det,
    output wire logic        intr_det,
    // Event stream, one per cycle, no back-pressure
    output logic             evt_valid,
    output logic      [3:0]  evt_code,
    output logic      [31:0] evt_data,
    output logic      [31:0] evt_stamp
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                  blk_s1_r;
    logic                  blk_s2_r;
    logic                  aw_have_r;
    logic [7:0]            aw_addr_r;
    logic                  w_have_r;
    logic [31:0]           w_data_r;
    logic [3:0]            w_strb_r;
    logic                  en_r;
    logic [15:0]           sag_lim_r;
    logic [15:0]           swl_lim_r;
    logic [15:0]           int_lim_r;
    logic [15:0]           min_dur_r;
    logic [15:0]           max_dur_r;
    vdm_pkg::vdm_state_t   state_r;
    vdm_pkg::vdm_state_t   state_nxt;
    vdm_pkg::vdm_kind_t    kind_r;
    vdm_pkg::vdm_kind_t    kind_nxt;
    logic [15:0]           dur_r;
    logic [15:0]           dur_nxt;
    logic [15:0]           sag_cnt_r;
    logic [15:0]           swl_cnt_r;
    logic [15:0]           last_dur_r;
    logic [2:0][15:0]      last_v_r;
    logic [2:0]            det_r;
    logic [11:0]           pend_r;
    logic [31:0]           ms_cnt_r;
    logic                  inc_sag;
    logic                  inc_swl;
    logic                  rpt;
    logic [3:0]            ev_idx;
    wire                   ms_tick;
    wire                   any_below_sag;
    wire                   all_below_int;
    wire                   any_above_swl;
    wire [2:0][15:0]       ext;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            blk_s1_r <= 1'b0;
            blk_s2_r <= 1'b0;
        end else begin
            blk_s1_r <= block_pin;
            blk_s2_r <= blk_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux

    function automatic logic [31:0] reg_rd(input logic [7:0] a);
        case (a)
            `VDM_CTRL:     reg_rd = {31'h0000_0000, en_r};
            `VDM_SAG_LIM:  reg_rd = {16'h0000, sag_lim_r};
            `VDM_SWL_LIM:  reg_rd = {16'h0000, swl_lim_r};
            `VDM_INT_LIM:  reg_rd = {16'h0000, int_lim_r};
            `VDM_MIN_DUR:  reg_rd = {16'h0000, min_dur_r};
            `VDM_MAX_DUR:  reg_rd = {16'h0000, max_dur_r};
            `VDM_STATUS:   reg_rd = {28'h000_0000, blk_s2_r, det_r};
            `VDM_SAG_CNT:  reg_rd = {16'h0000, sag_cnt_r};
            `VDM_SWL_CNT:  reg_rd = {16'h0000, swl_cnt_r};
            `VDM_LAST_DUR: reg_rd = {16'h0000, last_dur_r};
            `VDM_LAST_V1:  reg_rd = {16'h0000, last_v_r[0]};
            `VDM_LAST_V2:  reg_rd = {16'h0000, last_v_r[1]};
            `VDM_LAST_V3:  reg_rd = {16'h0000, last_v_r[2]};
            default:       reg_rd = 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    // Address and data are held until both are in, then one response
    wire        wr_go   = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire        aw_hit  = (aw_addr_r[1:0] == 2'b00) && (aw_addr_r <= `VDM_LAST_V3);
    wire [31:0] wmask   = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [31:0] wr_val  = (reg_rd(aw_addr_r) & ~wmask) | (w_data_r & wmask);
    wire        wr_ctrl = wr_go & (aw_addr_r == `VDM_CTRL);
    wire        clr_sag = wr_ctrl & wr_val[`VDM_CTRL_CLR_SAG];
    wire        clr_swl = wr_ctrl & wr_val[`VDM_CTRL_CLR_SWL];

    assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_have_r    <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_have_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `VDM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_hit ? `VDM_RESP_OKAY : `VDM_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire ar_hit  = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `VDM_LAST_V3);

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `VDM_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= reg_rd(s_axi_araddr);
            s_axi_rresp  <= ar_hit ? `VDM_RESP_OKAY : `VDM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_r      <= `VDM_CTRL_EN_RST;
            sag_lim_r <= `VDM_SAG_LIM_RST;
            swl_lim_r <= `VDM_SWL_LIM_RST;
            int_lim_r <= `VDM_INT_LIM_RST;
            min_dur_r <= `VDM_MIN_DUR_RST;
            max_dur_r <= `VDM_MAX_DUR_RST;
        end else if (wr_go) begin
            case (aw_addr_r)
                `VDM_CTRL:    en_r      <= wr_val[`VDM_CTRL_EN];
                `VDM_SAG_LIM: sag_lim_r <= wr_val[15:0];
                `VDM_SWL_LIM: swl_lim_r <= wr_val[15:0];
                `VDM_INT_LIM: int_lim_r <= wr_val[15:0];
                `VDM_MIN_DUR: min_dur_r <= wr_val[15:0];
                `VDM_MAX_DUR: max_dur_r <= wr_val[15:0];
                default:      en_r      <= en_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Detection

    vdm_ms_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ms_tick  (ms_tick)
    );

    vdm_phase_cmp u_cmp (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .volt          ({volt_ca, volt_bc, volt_ab}),
        .sag_lim       (sag_lim_r),
        .swl_lim       (swl_lim_r),
        .int_lim       (int_lim_r),
        .restart       (state_r == vdm_pkg::VDM_ST_IDLE),
        .track_max     (kind_r == vdm_pkg::VDM_K_SWL),
        .any_below_sag (any_below_sag),
        .all_below_int (all_below_int),
        .any_above_swl (any_above_swl),
        .ext           (ext)
    );

    // Blocking input or disable suspends detection entirely
    wire en    = en_r & ~blk_s2_r;
    wire int_c = en & all_below_int;
    wire sag_c = en & any_below_sag & ~all_below_int;
    wire swl_c = en & any_above_swl;
    wire is_sag = (kind_r == vdm_pkg::VDM_K_SAG);
    wire is_swl = (kind_r == vdm_pkg::VDM_K_SWL);
    wire is_int = (kind_r == vdm_pkg::VDM_K_INT);
    wire back  = (is_sag & ~any_below_sag)
               | (is_swl & ~any_above_swl)
               | (is_int & ~all_below_int);
    wire expd  = (dur_r >= max_dur_r);
    wire in_win = (dur_r >= min_dur_r) & ~expd;

    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        dur_nxt   = dur_r;
        inc_sag   = 1'b0;
        inc_swl   = 1'b0;
        rpt       = 1'b0;
        case (state_r)
            vdm_pkg::VDM_ST_IDLE: begin
                dur_nxt   = 16'h0000;
                state_nxt = (int_c | sag_c | swl_c) ? vdm_pkg::VDM_ST_RUN : vdm_pkg::VDM_ST_IDLE;
                kind_nxt  = int_c ? vdm_pkg::VDM_K_INT :
                            sag_c ? vdm_pkg::VDM_K_SAG :
                            swl_c ? vdm_pkg::VDM_K_SWL : vdm_pkg::VDM_K_NONE;
            end
            vdm_pkg::VDM_ST_RUN: begin
                if (ms_tick && dur_r != 16'hFFFF) begin
                    dur_nxt = dur_r + 16'h0001;
                end
                if (!en) begin
                    state_nxt = vdm_pkg::VDM_ST_IDLE;
                end else if (back) begin
                    state_nxt = vdm_pkg::VDM_ST_IDLE;
                    rpt       = 1'b1;
                    inc_sag   = is_sag & in_win;
                    inc_swl   = is_swl & in_win;
                end else if (is_sag && int_c) begin
                    // Dip deepens into an outage: close the dip uncounted
                    state_nxt = vdm_pkg::VDM_ST_IDLE;
                    rpt       = 1'b1;
                end else if (expd) begin
                    state_nxt = vdm_pkg::VDM_ST_EXP;
                    rpt       = 1'b1;
                end
            end
            vdm_pkg::VDM_ST_EXP: begin
                // Output already dropped; wait for normal before re-arming
                if (!en || back) begin
                    state_nxt = vdm_pkg::VDM_ST_IDLE;
                end
            end
            default: begin
                state_nxt = vdm_pkg::VDM_ST_IDLE;
                kind_nxt  = vdm_pkg::VDM_K_NONE;
            end
        endcase
    end

    wire       run_nxt = (state_nxt == vdm_pkg::VDM_ST_RUN);
    wire [2:0] det_nxt = {run_nxt & (kind_nxt == vdm_pkg::VDM_K_INT),
                          run_nxt & (kind_nxt == vdm_pkg::VDM_K_SWL),
                          run_nxt & (kind_nxt == vdm_pkg::VDM_K_SAG)};

    assign sag_det   = det_r[0];
    assign swell_det = det_r[1];
    assign intr_det  = det_r[2];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= vdm_pkg::VDM_ST_IDLE;
            kind_r  <= vdm_pkg::VDM_K_NONE;
            dur_r   <= 16'h0000;
            det_r   <= 3'b000;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            dur_r   <= dur_nxt;
            det_r   <= det_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counters and report

    // A clear and an increment together leave the count at one
    wire [15:0] sag_cnt_nxt = (clr_sag ? 16'h0000 : sag_cnt_r) + {15'h0000, inc_sag};
    wire [15:0] swl_cnt_nxt = (clr_swl ? 16'h0000 : swl_cnt_r) + {15'h0000, inc_swl};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sag_cnt_r  <= 16'h0000;
            swl_cnt_r  <= 16'h0000;
            last_dur_r <= 16'h0000;
            last_v_r   <= '0;
        end else begin
            sag_cnt_r <= sag_cnt_nxt;
            swl_cnt_r <= swl_cnt_nxt;
            if (rpt) begin
                last_dur_r <= dur_r;
                last_v_r   <= ext;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event stream

    wire [2:0]  on_e   = det_nxt & ~det_r;
    wire [2:0]  off_e  = ~det_nxt & det_r;
    wire [11:0] ev_set = {{4{rpt}}, clr_swl | inc_swl, clr_sag | inc_sag,
                          off_e[2], on_e[2], off_e[1], on_e[1], off_e[0], on_e[0]};

    // Lowest code first, so an off event precedes its count and report
    always_comb begin
        ev_idx = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (pend_r[i]) begin
                ev_idx = 4'(i);
            end
        end
    end

    wire [11:0] grant   = pend_r[ev_idx] ? (12'h001 << ev_idx) : 12'h000;
    wire [31:0] ev_data =
        (ev_idx <= vdm_pkg::VDM_EV_INT_OFF)   ? {31'h0000_0000, ~ev_idx[0]} :
        (ev_idx == vdm_pkg::VDM_EV_SAG_CNT)   ? {16'h0000, sag_cnt_r} :
        (ev_idx == vdm_pkg::VDM_EV_SWL_CNT)   ? {16'h0000, swl_cnt_r} :
        (ev_idx == vdm_pkg::VDM_EV_LAST_DUR)  ? {16'h0000, last_dur_r} :
        (ev_idx == vdm_pkg::VDM_EV_LAST_V1)   ? {16'h0000, last_v_r[0]} :
        (ev_idx == vdm_pkg::VDM_EV_LAST_V2)   ? {16'h0000, last_v_r[1]} :
                                                {16'h0000, last_v_r[2]};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pend_r    <= 12'h000;
            ms_cnt_r  <= 32'h0000_0000;
            evt_valid <= 1'b0;
            evt_code  <= 4'h0;
            evt_data  <= 32'h0000_0000;
            evt_stamp <= 32'h0000_0000;
        end else begin
            pend_r    <= (pend_r & ~grant) | ev_set;
            ms_cnt_r  <= ms_cnt_r + {31'h0000_0000, ms_tick};
            evt_valid <= |pend_r;
            evt_code  <= ev_idx;
            evt_data  <= ev_data;
            evt_stamp <= ms_cnt_r;
        end
    end

endmodule

// File: hw/vdm_regs.svh
`ifndef VDM_REGS_SVH
`define VDM_REGS_SVH

// Register byte offsets
`define VDM_CTRL      8'h00
`define VDM_SAG_LIM   8'h04
`define VDM_SWL_LIM   8'h08
`define VDM_INT_LIM   8'h0C
`define VDM_MIN_DUR   8'h10
`define VDM_MAX_DUR   8'h14
`define VDM_STATUS    8'h18
`define VDM_SAG_CNT   8'h1C
`define VDM_SWL_CNT   8'h20
`define VDM_LAST_DUR  8'h24
`define VDM_LAST_V1   8'h28
`define VDM_LAST_V2   8'h2C
`define VDM_LAST_V3   8'h30

// Control fields
`define VDM_CTRL_EN      0
`define VDM_CTRL_CLR_SAG 1
`define VDM_CTRL_CLR_SWL 2

// Reset values
`define VDM_CTRL_EN_RST  1'b1
`define VDM_SAG_LIM_RST  16'h005A
`define VDM_SWL_LIM_RST  16'h006E
`define VDM_INT_LIM_RST  16'h000A
`define VDM_MIN_DUR_RST  16'h000A
`define VDM_MAX_DUR_RST  16'hEA60

// Bus answers
`define VDM_RESP_OKAY    2'b00
`define VDM_RESP_SLVERR  2'b10

// Timing
`define VDM_CLK_HZ       10000000
`define VDM_TICK_MS      1
`define VDM_TICK_CYCLES  (`VDM_CLK_HZ / 1000 * `VDM_TICK_MS)

`endif

// File: hw/vdm_pkg.sv
package vdm_pkg;

    typedef enum logic [1:0] {
        VDM_ST_IDLE = 2'b00,
        VDM_ST_RUN  = 2'b01,
        VDM_ST_EXP  = 2'b10
    } vdm_state_t;

    typedef enum logic [1:0] {
        VDM_K_NONE = 2'b00,
        VDM_K_SAG  = 2'b01,
        VDM_K_SWL  = 2'b10,
        VDM_K_INT  = 2'b11
    } vdm_kind_t;

    // On events carry even codes, off events odd ones
    typedef enum logic [3:0] {
        VDM_EV_SAG_ON   = 4'h0,
        VDM_EV_SAG_OFF  = 4'h1,
        VDM_EV_SWL_ON   = 4'h2,
        VDM_EV_SWL_OFF  = 4'h3,
        VDM_EV_INT_ON   = 4'h4,
        VDM_EV_INT_OFF  = 4'h5,
        VDM_EV_SAG_CNT  = 4'h6,
        VDM_EV_SWL_CNT  = 4'h7,
        VDM_EV_LAST_DUR = 4'h8,
        VDM_EV_LAST_V1  = 4'h9,
        VDM_EV_LAST_V2  = 4'hA,
        VDM_EV_LAST_V3  = 4'hB
    } vdm_evt_t;

endpackage

// File: hw/vdm_ms_tick.sv
`timescale 1ns/10ps
`include "vdm_regs.svh"

module vdm_ms_tick #(
    parameter int CYCLES = `VDM_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // One-cycle pulse per millisecond
    output logic      ms_tick
);

    logic [23:0] cnt_r;
    wire         wrap = (cnt_r == 24'(CYCLES - 1));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_r   <= 24'h00_0000;
            ms_tick <= 1'b0;
        end else begin
            cnt_r   <= wrap ? 24'h00_0000 : cnt_r + 24'h00_0001;
            ms_tick <= wrap;
        end
    end

endmodule

// File: hw/vdm_phase_cmp.sv
`timescale 1ns/10ps

module vdm_phase_cmp (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Magnitudes and limits
    input  wire logic [2:0][15:0] volt,
    input  wire logic [15:0]      sag_lim,
    input  wire logic [15:0]      swl_lim,
    input  wire logic [15:0]      int_lim,
    // Extreme tracking
    input  wire logic             restart,
    input  wire logic             track_max,
    // Results
    output wire logic             any_below_sag,
    output wire logic             all_below_int,
    output wire logic             any_above_swl,
    output wire logic [2:0][15:0] ext
);

    wire [2:0] blw_sag;
    wire [2:0] blw_int;
    wire [2:0] abv_swl;

    assign any_below_sag = |blw_sag;
    assign all_below_int = &blw_int;
    assign any_above_swl = |abv_swl;

    for (genvar p = 0; p < 3; p++) begin : g_ph
        logic [15:0] min_r;
        logic [15:0] max_r;
        // A phase under the outage level reports zero as its low point
        wire  [15:0] floor_v = blw_int[p] ? 16'h0000 : volt[p];

        assign blw_sag[p] = volt[p] < sag_lim;
        assign blw_int[p] = volt[p] < int_lim;
        assign abv_swl[p] = volt[p] > swl_lim;
        assign ext[p]     = track_max ? max_r : min_r;

        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                min_r <= 16'h0000;
                max_r <= 16'h0000;
            end else if (restart) begin
                min_r <= floor_v;
                max_r <= volt[p];
            end else begin
                min_r <= (floor_v < min_r) ? floor_v : min_r;
                max_r <= (volt[p] > max_r) ? volt[p] : max_r;
            end
        end
    end

endmodule

// File: dv/vdm_top_assertions.sv
`timescale 1ns/10ps
`include "vdm_regs.svh"

module vdm_top_chk #(
    parameter int TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // Magnitudes
    input wire logic [15:0] volt_ab,
    input wire logic [15:0] volt_bc,
    input wire logic [15:0] volt_ca,
    // Status and events
    input wire logic        sag_det,
    input wire logic        swell_det,
    input wire logic        intr_det,
    input wire logic        evt_valid,
    input wire logic [3:0]  evt_code,
    input wire logic [31:0] evt_data
);
    // Limits held at reset values; the bench never rewrites them
    localparam logic [15:0] SL = `VDM_SAG_LIM_RST;
    localparam logic [15:0] WL = `VDM_SWL_LIM_RST;
    localparam logic [15:0] IL = `VDM_INT_LIM_RST;
    wire logic [2:0] lo = {volt_ab < SL, volt_bc < SL, volt_ca < SL};
    wire logic [2:0] hi = {volt_ab > WL, volt_bc > WL, volt_ca > WL};
    wire logic [2:0] dn = {volt_ab < IL, volt_bc < IL, volt_ca < IL};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_DIP_CAUSE: assert property ($rose(sag_det) |-> $past(|lo && !(&dn)))
        else $error("dip raised without cause");
    AST_DIP_END: assert property ((sag_det && !(|lo)) |=> !sag_det)
        else $error("dip held after return");
    AST_RISE_CAUSE: assert property ($rose(swell_det) |-> $past(|hi))
        else $error("rise raised without cause");
    AST_RISE_END: assert property ((swell_det && !(|hi)) |=> !swell_det)
        else $error("rise held after return");
    AST_OUT_CAUSE: assert property ($rose(intr_det) |-> $past(&dn))
        else $error("outage raised without cause");
    AST_OUT_END: assert property ((intr_det && !(&dn)) |=> !intr_det)
        else $error("outage held after return");
    AST_ONE_KIND: assert property ($onehot0({sag_det, swell_det, intr_det}))
        else $error("two statuses at once");
    AST_DIP_ON_EVT: assert property ($rose(sag_det) |=> evt_valid && evt_code == 4'h0 && evt_data == 32'h0000_0001)
        else $error("dip on event missing");
    AST_DIP_OFF_EVT: assert property ($fell(sag_det) |=> evt_valid && evt_code == 4'h1)
        else $error("dip off event missing");
    AST_OUT_NO_CNT: assert property ($fell(intr_det) |=> evt_code == 4'h5 ##1 evt_valid && evt_code == 4'h8)
        else $error("outage end not followed by report");
endmodule

bind vdm_top vdm_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
    .core_clk, .sys_rst, .volt_ab, .volt_bc, .volt_ca,
    .sag_det, .swell_det, .intr_det, .evt_valid, .evt_code, .evt_data);

// File: dv/vdm_grid_model.sv
`timescale 1ns/10ps

// Measurement chain in front, event recorder behind
module vdm_grid_model (
    // Clock
    input  wire logic        core_clk,
    // Magnitudes to the block
    output logic      [15:0] volt_ab,
    output logic      [15:0] volt_bc,
    output logic      [15:0] volt_ca,
    // Event stream, never stalled
    input  wire logic        evt_valid,
    input  wire logic [3:0]  evt_code,
    input  wire logic [31:0] evt_data
);
    logic [3:0]  log_c [$];
    logic [31:0] log_d [$];

    initial begin
        volt_ab = 16'h0064;
        volt_bc = 16'h0064;
        volt_ca = 16'h0064;
    end

    task automatic set_v(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge core_clk);
        volt_ab <= a;
        volt_bc <= b;
        volt_ca <= c;
    endtask

    always @(posedge core_clk) begin
        if (evt_valid) begin
            log_c.push_back(evt_code);
            log_d.push_back(evt_data);
        end
    end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/10ps
`include "vdm_regs.svh"

module tb_top;
    localparam logic [1:0]  OK = `VDM_RESP_OKAY;
    localparam logic [1:0]  ER = `VDM_RESP_SLVERR;
    localparam logic [15:0] VN = 16'h0064;
    localparam logic [15:0] VD = 16'h0055;
    localparam logic [15:0] VH = 16'h0073;
    localparam logic [15:0] VO = 16'h0005;
    logic        core_clk = 0;
    logic        sys_rst = 1;
    logic [7:0]  s_axi_awaddr = 0;
    logic [7:0]  s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, block_pin = 0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, evt_data, evt_stamp;
    wire logic [15:0] volt_ab, volt_bc, volt_ca;
    wire logic   sag_det, swell_det, intr_det, evt_valid;
    wire logic [3:0]  evt_code;
    logic [3:0]  ev_exp [7] = '{4'h0, 4'h1, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB};
    int          fail_count = 0;
    int          checked = 0;
    int          cyc = 0;

    always #50 core_clk = ~core_clk;

    // Short tick so one millisecond is ten cycles
    vdm_top #(.TICK_CYCLES(10)) i_dut (.*);

    vdm_grid_model i_grid (.*);

    // Cycles since reset release, to predict the millisecond stamp
    always @(posedge core_clk) cyc <= sys_rst ? 0 : cyc + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Ready is sampled mid-cycle; it only moves on rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw = 1;
        logic w = 1;
        logic b = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!b) begin
            @(negedge core_clk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            b = s_axi_bvalid;
            if (b) chk(s_axi_bresp, er);
            @(posedge core_clk);
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        s_axi_bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar = 1;
        logic r = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!r) begin
            @(negedge core_clk);
            ar = ar && !s_axi_arready;
            r = s_axi_rvalid;
            if (r) chk(s_axi_rdata, ed);
            if (r) chk(s_axi_rresp, er);
            @(posedge core_clk);
            s_axi_arvalid <= ar;
        end
        s_axi_rready <= 0;
    endtask

    task automatic dly(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic drive(input logic [15:0] a, b, c, input int n);
        i_grid.set_v(a, b, c);
        dly(n);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 0;
        rd(`VDM_CTRL, 32'h0000_0001, OK);
        rd(8'h34, 32'h0000_0000, ER);
        wr(8'h34, 32'h0000_0001, ER);
        wr(`VDM_SAG_CNT, 32'h0000_00FF, OK);
        rd(`VDM_SAG_CNT, 32'h0000_0000, OK);
        wr(`VDM_MIN_DUR, 32'h0000_0003, OK);
        wr(`VDM_MAX_DUR, 32'h0000_0014, OK);
        // Counted dip with full event trail
        drive(VD, VN, VN, 3);
        chk(sag_det, 1);
        dly(50);
        drive(VN, VN, VN, 20);
        chk(i_grid.log_c.size(), 7);
        foreach (ev_exp[i]) chk(i_grid.log_c[i], ev_exp[i]);
        chk(i_grid.log_d[2], 1);
        chk(evt_stamp, (cyc - 2) / 10);
        rd(`VDM_SAG_CNT, 32'h0000_0001, OK);
        rd(`VDM_LAST_V1, 32'h0000_0055, OK);
        rd(`VDM_LAST_V2, 32'h0000_0064, OK);
        // Dip shorter than the minimum
        drive(VD, VN, VN, 10);
        drive(VN, VN, VN, 20);
        rd(`VDM_SAG_CNT, 32'h0000_0001, OK);
        // Counted rise on one phase
        drive(VN, VH, VN, 3);
        chk(swell_det, 1);
        dly(50);
        drive(VN, VN, VN, 20);
        rd(`VDM_SWL_CNT, 32'h0000_0001, OK);
        rd(`VDM_LAST_V2, 32'h0000_0073, OK);
        rd(`VDM_LAST_V1, 32'h0000_0064, OK);
        // Dip outlasting the maximum
        drive(VD, VD, VD, 250);
        chk(sag_det, 0);
        rd(`VDM_LAST_DUR, 32'h0000_0014, OK);
        drive(VN, VN, VN, 20);
        rd(`VDM_SAG_CNT, 32'h0000_0001, OK);
        // Dip deepening into a full outage, neither counted
        drive(VD, VD, VD, 3);
        drive(VO, VO, VO, 3);
        chk(intr_det, 1);
        chk(sag_det, 0);
        dly(50);
        drive(VN, VN, VN, 20);
        rd(`VDM_SAG_CNT, 32'h0000_0001, OK);
        rd(`VDM_SWL_CNT, 32'h0000_0001, OK);
        rd(`VDM_LAST_V3, 32'h0000_0000, OK);
        // One phase below the outage limit
        drive(VO, VN, VN, 3);
        chk(sag_det, 1);
        dly(50);
        drive(VN, VN, VN, 20);
        rd(`VDM_SAG_CNT, 32'h0000_0002, OK);
        rd(`VDM_LAST_V1, 32'h0000_0000, OK);
        rd(`VDM_LAST_V2, 32'h0000_0064, OK);
        // Separate count clears
        wr(`VDM_CTRL, 32'h0000_0003, OK);
        rd(`VDM_SAG_CNT, 32'h0000_0000, OK);
        rd(`VDM_SWL_CNT, 32'h0000_0001, OK);
        wr(`VDM_CTRL, 32'h0000_0005, OK);
        rd(`VDM_SWL_CNT, 32'h0000_0000, OK);
        print_verdict();
    end
endmodule
